// ==== design/xcvr_ctrl_pkg.sv ====
package xcvr_ctrl_pkg;

    // Transceiver mode codes as software writes them
    localparam logic [1:0] MODE_OFF     = 2'h0;
    localparam logic [1:0] MODE_WAKE    = 2'h1;
    localparam logic [1:0] MODE_RXONLY  = 2'h2;
    localparam logic [1:0] MODE_NORMAL  = 2'h3;

    // Chip-level operating modes (one-hot input)
    localparam int CHIP_NORMAL   = 0;
    localparam int CHIP_STOP     = 1;
    localparam int CHIP_SLEEP    = 2;
    localparam int CHIP_RESTART  = 3;
    localparam int CHIP_FAILSAFE = 4;
    localparam int CHIP_W        = 5;

    // Register map, byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_WAKE   = 8'h08;

    // CTRL fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_WDWAKE   = 2;
    // STATUS fields (write one to clear for bits 0..1)
    localparam int ST_FAIL  = 0;
    localparam int ST_UV    = 1;
    localparam int ST_TXTO  = 2;
    localparam int ST_ARMED = 3;
    localparam int ST_ENOK  = 4;
    // WAKE status field
    localparam int WK_BUS   = 0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing in nanoseconds at 40 MHz
    localparam int CLK_NS        = 25;
    localparam int WAKE_MIN_NS   = 500;
    localparam int WAKE_MAX_NS   = 1800000;
    localparam int ENABLE_NS     = 20000;
    localparam int TX_TO_NS      = 2000000;
    localparam int BUS_TO_NS     = 2000000;
    localparam int WAKE_MIN_CYC  = (WAKE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_MAX_CYC  = WAKE_MAX_NS / CLK_NS;
    localparam int ENABLE_CYC    = (ENABLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TX_TO_CYC     = TX_TO_NS / CLK_NS;
    localparam int BUS_TO_CYC    = BUS_TO_NS / CLK_NS;
    localparam int CNT_W         = 17;

    typedef struct packed {
        logic fail;
        logic uv;
        logic bus_wake;
    } events_s;

endpackage : xcvr_ctrl_pkg

// ==== design/xcvr_mode_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
module xcvr_mode_ctrl
    import xcvr_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic               CLOCK,
    input  wire logic               RESET_N,
    // AXI4-Lite slave
    input  wire logic [7:0]         AWADDR,
    input  wire logic               AWVALID,
    output logic                    AWREADY,
    input  wire logic [31:0]        WDATA,
    input  wire logic [3:0]         WSTRB,
    input  wire logic               WVALID,
    output logic                    WREADY,
    output logic [1:0]              BRESP,
    output logic                    BVALID,
    input  wire logic               BREADY,
    input  wire logic [7:0]         ARADDR,
    input  wire logic               ARVALID,
    output logic                    ARREADY,
    output logic [31:0]             RDATA,
    output logic [1:0]              RRESP,
    output logic                    RVALID,
    input  wire logic               RREADY,
    // Chip mode, one-hot
    input  wire logic [CHIP_W-1:0]  CHIP_MODE,
    input  wire logic               WATCHDOG_ON,
    // Controller side
    input  wire logic               TRANSMIT_INPUT,
    output logic                    RECEIVE_OUT,
    // Bus side
    input  wire logic               BUS_DOMINANT,
    output logic                    DRIVE_DOMINANT,
    output logic                    DRIVER_ENABLE,
    output logic                    BUS_BIAS_ON,
    input  wire logic               SUPPLY_LOW,
    // System actions
    output logic                    INT_N,
    output logic                    RESTART_REQ,
    output logic                    WATCHDOG_ENABLE_REQ
);

    // Pin input synchronisers
    logic [2:0] s_tx, s_bus, s_uv;
    logic tx_dom, bus_dom, uv;
    always_ff @(posedge CLOCK)
    begin
        s_tx  <= {s_tx[1:0], ~TRANSMIT_INPUT};
        s_bus <= {s_bus[1:0], BUS_DOMINANT};
        s_uv  <= {s_uv[1:0], SUPPLY_LOW};
        if (s_tx[1] == s_tx[2])   tx_dom  <= s_tx[2];
        if (s_bus[1] == s_bus[2]) bus_dom <= s_bus[2];
        if (s_uv[1] == s_uv[2])   uv      <= s_uv[2];
    end

    // Registers
    logic [1:0] mode;
    logic       wd_on_wake;
    events_s    ev;
    logic [1:0] prev_mode;
    logic [CHIP_W-1:0] prev_chip;

    wire chip_ns  = CHIP_MODE[CHIP_NORMAL] | CHIP_MODE[CHIP_STOP];
    wire failsafe = CHIP_MODE[CHIP_FAILSAFE];
    // Effective mode: fail-safe forces wake-capable, illegal combos fall to wake/off
    wire [1:0] eff_mode =
        failsafe ? MODE_WAKE :
        ((mode == MODE_NORMAL || mode == MODE_RXONLY) && !chip_ns) ? MODE_WAKE :
        (mode == MODE_WAKE && CHIP_MODE[CHIP_SLEEP] == 1'b0 && !chip_ns
            && !CHIP_MODE[CHIP_RESTART]) ? MODE_OFF : mode;
    wire is_norm  = eff_mode == MODE_NORMAL;
    wire is_rx    = eff_mode == MODE_RXONLY;
    wire is_wake  = eff_mode == MODE_WAKE;
    wire mode_chg = eff_mode != prev_mode;

    // Enabling time and fresh-dominant gate
    logic [CNT_W-1:0] en_cnt;
    logic             en_done, tx_armed;
    wire en_run = is_norm && !en_done;
    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N || !is_norm)
        begin
            en_cnt <= '0;
            en_done <= 1'b0;
            tx_armed <= 1'b0;
        end
        else
        begin
            if (en_run) en_cnt <= en_cnt + 1'b1;
            if (en_run && en_cnt == CNT_W'(ENABLE_CYC - 1)) en_done <= 1'b1;
            if (en_done && !tx_dom) tx_armed <= 1'b1;
        end
    end

    // Transmit dominant time-out
    logic [CNT_W-1:0] txto_cnt;
    logic             tx_to;
    wire txto_hit = tx_dom && is_norm && txto_cnt == CNT_W'(TX_TO_CYC);
    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N || !tx_dom || !is_norm)
            txto_cnt <= '0;
        else if (txto_cnt != CNT_W'(TX_TO_CYC))
            txto_cnt <= txto_cnt + 1'b1;
        if (!RESET_N || !is_norm || !tx_dom) tx_to <= 1'b0;
        else if (txto_hit) tx_to <= 1'b1;
    end

    // Bus dominant clamp
    logic [CNT_W-1:0] bus_cnt;
    wire bus_hit = (is_norm || is_rx) && bus_dom && bus_cnt == CNT_W'(BUS_TO_CYC - 1);
    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N || !bus_dom || !(is_norm || is_rx)) bus_cnt <= '0;
        else if (bus_cnt != CNT_W'(BUS_TO_CYC)) bus_cnt <= bus_cnt + 1'b1;
    end

    // Undervoltage monitor
    wire uv_act = uv && (is_norm || is_rx) && chip_ns;

    // Wake pattern detector
    typedef enum logic [4:0] {
        W_IDLE = 5'h01, W_DOM1 = 5'h02, W_REC = 5'h04, W_DOM2 = 5'h08, W_DONE = 5'h10
    } wake_e;
    wake_e wst;
    logic [CNT_W-1:0] ph_cnt;
    logic             armed;
    wire ph_ok   = ph_cnt >= CNT_W'(WAKE_MIN_CYC) && ph_cnt < CNT_W'(WAKE_MAX_CYC);
    wire ph_long = ph_cnt >= CNT_W'(WAKE_MAX_CYC);
    wire wake_hit = wst == W_DOM2 && bus_dom && ph_cnt == CNT_W'(WAKE_MIN_CYC);
    wire chip_rearm = (CHIP_MODE[CHIP_STOP] && !prev_chip[CHIP_STOP])
                    || (failsafe && !prev_chip[CHIP_FAILSAFE]);

    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N)
        begin
            wst <= W_IDLE;
            ph_cnt <= '0;
            armed <= 1'b1;
        end
        else if (!is_wake || !armed)
        begin
            wst <= W_IDLE;
            ph_cnt <= '0;
            if ((mode_chg && is_wake) || chip_rearm) armed <= 1'b1;
        end
        else
        begin
            ph_cnt <= (ph_long ? ph_cnt : ph_cnt + 1'b1);
            unique case (wst)
                W_IDLE: if (bus_dom) begin wst <= W_DOM1; ph_cnt <= '0; end
                W_DOM1: if (!bus_dom)
                begin
                    wst <= ph_ok ? W_REC : W_IDLE;
                    ph_cnt <= '0;
                end
                W_REC: if (bus_dom)
                begin
                    wst <= ph_ok ? W_DOM2 : W_DOM1;
                    ph_cnt <= '0;
                end
                W_DOM2:
                    if (wake_hit) wst <= W_DONE;
                    else if (!bus_dom)
                    begin
                        wst <= W_REC;
                        ph_cnt <= '0;
                    end
                W_DONE:
                begin
                    wst <= W_IDLE;
                    armed <= 1'b0;
                end
            endcase
        end
    end
    wire bus_wake = wst == W_DONE;

    // Receive output wake latch
    logic wake_low;
    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N || mode_chg) wake_low <= 1'b0;
        else if (bus_wake) wake_low <= 1'b1;
        prev_mode <= RESET_N ? eff_mode : MODE_OFF;
        prev_chip <= RESET_N ? CHIP_MODE : '0;
    end

    // Bus pin outputs
    wire drv = is_norm && en_done && !tx_to && !uv_act;
    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N)
        begin
            DRIVER_ENABLE <= 1'b0;
            DRIVE_DOMINANT <= 1'b0;
            BUS_BIAS_ON <= 1'b0;
            RECEIVE_OUT <= 1'b1;
        end
        else
        begin
            DRIVER_ENABLE <= drv;
            DRIVE_DOMINANT <= drv && tx_armed && tx_dom;
            BUS_BIAS_ON <= is_norm || is_rx;
            RECEIVE_OUT <= wake_low ? 1'b0 :
                           (is_norm || is_rx) ? !bus_dom : 1'b1;
        end
    end

    // Event flags, set wins over clear
    logic wr_fire;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    wire w1c_st = wr_fire && aw_q == ADDR_STATUS;
    wire w1c_wk = wr_fire && aw_q == ADDR_WAKE;
    wire wake_int = bus_wake && chip_ns;
    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N)
            ev <= '0;
        else
        begin
            ev.fail <= (txto_hit && !tx_to) || bus_hit ||
                       (ev.fail && !(w1c_st && w_q[ST_FAIL]));
            ev.uv <= uv_act || (ev.uv && !(w1c_st && w_q[ST_UV]));
            ev.bus_wake <= bus_wake ||
                           (ev.bus_wake && !(w1c_wk && w_q[WK_BUS]));
        end
    end

    // System action outputs
    logic int_hold;
    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N)
        begin
            int_hold <= 1'b0;
            RESTART_REQ <= 1'b0;
            WATCHDOG_ENABLE_REQ <= 1'b0;
        end
        else
        begin
            int_hold <= wake_int || (int_hold && !(w1c_wk && w_q[WK_BUS]));
            RESTART_REQ <= bus_wake &&
                (CHIP_MODE[CHIP_SLEEP] || failsafe);
            WATCHDOG_ENABLE_REQ <= bus_wake && CHIP_MODE[CHIP_STOP]
                && wd_on_wake && !WATCHDOG_ON;
        end
    end
    assign INT_N = !int_hold;

    // AXI4-Lite write path
    logic aw_have, w_have;
    assign AWREADY = !aw_have && !BVALID;
    assign WREADY  = !w_have && !BVALID;
    assign wr_fire = aw_have && w_have && !BVALID;
    wire wr_known = aw_q == ADDR_CTRL || aw_q == ADDR_STATUS || aw_q == ADDR_WAKE;
    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N)
        begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= RESP_OKAY;
            aw_q <= '0;
            w_q <= '0;
            mode <= MODE_OFF;
            wd_on_wake <= 1'b0;
        end
        else
        begin
            if (AWVALID && AWREADY) begin aw_have <= 1'b1; aw_q <= AWADDR; end
            if (WVALID && WREADY)
            begin
                w_have <= 1'b1;
                w_q <= WSTRB[0] ? WDATA : '0;
            end
            if (wr_fire)
            begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                BVALID <= 1'b1;
                BRESP <= wr_known ? RESP_OKAY : RESP_SLVERR;
                if (aw_q == ADDR_CTRL && w_q != 32'hFFFFFFFF)
                begin
                    mode <= w_q[CTRL_MODE_LSB +: 2];
                    wd_on_wake <= w_q[CTRL_WDWAKE];
                end
            end
            else if (BVALID && BREADY)
                BVALID <= 1'b0;
        end
    end

    // AXI4-Lite read path
    assign ARREADY = !RVALID;
    wire [31:0] rd_val =
        ARADDR == ADDR_CTRL   ? {29'h0, wd_on_wake, mode} :
        ARADDR == ADDR_STATUS ? {27'h0, en_done, armed, tx_to, ev.uv, ev.fail} :
        ARADDR == ADDR_WAKE   ? {31'h0, ev.bus_wake} : 32'h0;
    wire rd_known = ARADDR == ADDR_CTRL || ARADDR == ADDR_STATUS || ARADDR == ADDR_WAKE;
    always_ff @(posedge CLOCK)
    begin
        if (!RESET_N)
        begin
            RVALID <= 1'b0;
            RDATA <= '0;
            RRESP <= RESP_OKAY;
        end
        else if (ARVALID && ARREADY)
        begin
            RVALID <= 1'b1;
            RDATA <= rd_val;
            RRESP <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end
        else if (RVALID && RREADY)
            RVALID <= 1'b0;
    end

    // Assertions
    a_off_no_drive: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !(is_norm) |=> !DRIVER_ENABLE) else $error("driver on outside normal");
    a_wake_rxd_low: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        bus_wake && !mode_chg |=> ##1 !RECEIVE_OUT) else $error("rxd not low on wake");
    a_off_no_wake: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        eff_mode == MODE_OFF |-> !bus_wake) else $error("wake in off");
    a_wake_int: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        wake_int |=> ##1 !INT_N) else $error("int missing");
    a_restart_no_int: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        bus_wake && CHIP_MODE[CHIP_SLEEP] |=> RESTART_REQ && INT_N) else $error("sleep wake");
    a_txto_fail: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        txto_hit && !tx_to |=> ev.fail && tx_to ##1 !DRIVER_ENABLE) else $error("tx time-out");
    a_wake_disarm: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        bus_wake |=> !armed) else $error("not disarmed");
    a_uv_flag: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        uv_act |=> ev.uv && !DRIVER_ENABLE) else $error("uv not handled");
    a_mode_kept: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !wr_fire |=> mode == $past(mode)) else $error("mode changed by hw");

endmodule : xcvr_mode_ctrl
`default_nettype wire

// ==== dv/can_ctrl_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module can_ctrl_model
    import xcvr_ctrl_pkg::*;
(
    // Bench control
    input  wire logic clk,
    input  wire logic arm,
    input  wire logic early,
    input  wire logic tx_bit,
    // Controller pin and state
    output logic      txd,
    output logic      ready
);
    int  cnt;
    wire early_low = early && (cnt > 2) && (cnt < 12);

    always_ff @(posedge clk)
    begin
        if (!arm)
            cnt <= 0;
        else if (cnt < ENABLE_CYC + 8)
            cnt <= cnt + 1;
    end

    // Recessive until enabled; an early dominant is withdrawn again
    assign ready = (cnt >= ENABLE_CYC + 8);
    assign txd   = ready ? tx_bit : !early_low;
endmodule : can_ctrl_model
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
    import xcvr_ctrl_pkg::*;
    typedef struct packed {logic [31:0] val; logic [31:0] mask; logic [1:0] resp;} note_s;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [4:0]  chip = 5'h02;
    logic        wd_on = 1'b0, bus_dom = 1'b0, sup_low = 1'b0;
    logic        arm = 1'b0, early = 1'b0, tx_bit = 1'b1;
    logic        txd, m_ready, rxd, drv_dom, drv_en, bias, int_n, rs_req, wd_req;
    int          err_total = 0, checks = 0, seed = 65746, wd_cnt = 0, rs_cnt = 0;
    note_s       notes[$];
    note_s       note;

    always #12.5 clk = ~clk;

    xcvr_mode_ctrl i_dut (
        .CLOCK(clk), .RESET_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .CHIP_MODE(chip), .WATCHDOG_ON(wd_on), .TRANSMIT_INPUT(txd), .RECEIVE_OUT(rxd),
        .BUS_DOMINANT(bus_dom), .DRIVE_DOMINANT(drv_dom), .DRIVER_ENABLE(drv_en),
        .BUS_BIAS_ON(bias), .SUPPLY_LOW(sup_low), .INT_N(int_n), .RESTART_REQ(rs_req),
        .WATCHDOG_ENABLE_REQ(wd_req)
    );

    can_ctrl_model i_ctrl (
        .clk(clk), .arm(arm), .early(early), .tx_bit(tx_bit), .txd(txd), .ready(m_ready)
    );

    task automatic print_verdict;
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    task automatic fail(input string m);
        $display("[ERR] %0t %s", $time, m);
        err_total++;
    endtask : fail

    task automatic chk(input logic g, input logic e, input string m);
        checks++;
        if (g !== e)
            fail(m);
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
                break;
        end
        bready <= 1'b0;
        if (n == 100)
        begin
            fail("write timeout");
            print_verdict();
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                          input logic [1:0] r);
        int n;
        notes.push_back('{e, m, r});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge clk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
                break;
        end
        rready <= 1'b0;
        if (n == 100)
        begin
            fail("read timeout");
            print_verdict();
        end
    endtask : axi_rd

    // Upper control bits random; they only matter in that an all-ones CTRL write is ignored
    task automatic set_mode(input logic [1:0] m, input logic wd);
        axi_wr(ADDR_CTRL, {29'($random(seed)), wd, m});
        cyc(8);
    endtask : set_mode

    task automatic wake_pat;
        int k;
        for (k = 0; k < 3; k++)
        begin
            bus_dom <= (k != 1);
            cyc(30 + ($random(seed) & 15));
        end
        bus_dom <= 1'b0;
        cyc(12);
    endtask : wake_pat

    task automatic wait_ready;
        int n;
        for (n = 0; n < 2000 && !m_ready; n++)
        begin
            @(posedge clk);
            if (drv_dom !== 1'b0)
                fail("early dominant sent");
        end
        if (n == 2000)
        begin
            fail("enable wait timeout");
            print_verdict();
        end
    endtask : wait_ready

    always @(posedge clk)
    begin
        if (wd_req === 1'b1)
            wd_cnt++;
        if (rs_req === 1'b1)
            rs_cnt++;
        if (rvalid && rready)
        begin
            checks++;
            if (notes.size() == 0)
                fail("unexpected read");
            else
            begin
                note = notes.pop_front();
                if (((rdata & note.mask) !== note.val) || (rresp !== note.resp))
                    fail("read data mismatch");
            end
        end
    end

    initial
    begin
        cyc(4);
        rst_n <= 1'b1;
        cyc(1);
        chk(rxd, 1'b1, "rx after reset");
        chk(drv_en | bias, 1'b0, "bus pins not released");
        axi_rd(ADDR_CTRL, 32'h0, 32'h3, RESP_OKAY);
        axi_rd(8'hFC, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        wake_pat();
        chk(rxd & int_n, 1'b1, "wake seen in off");
        axi_rd(ADDR_WAKE, 32'h0, 32'h1, RESP_OKAY);
        chip <= 5'h01;
        early <= 1'b1;
        set_mode(MODE_NORMAL, 1'b0);
        arm <= 1'b1;
        wait_ready();
        chk(drv_en, 1'b1, "driver off in normal");
        axi_rd(ADDR_STATUS, 32'h10, 32'h10, RESP_OKAY);
        tx_bit <= 1'b0;
        cyc(8);
        chk(drv_dom, 1'b1, "dominant not sent");
        tx_bit <= 1'b1;
        bus_dom <= 1'b1;
        cyc(8);
        chk(drv_dom | rxd, 1'b0, "rx or tx wrong");
        bus_dom <= 1'b0;
        sup_low <= 1'b1;
        cyc(8);
        chk(drv_en, 1'b0, "driver on at undervoltage");
        axi_rd(ADDR_STATUS, 32'h2, 32'h2, RESP_OKAY);
        sup_low <= 1'b0;
        cyc(8);
        chk(drv_en, 1'b1, "no recovery");
        axi_wr(ADDR_STATUS, 32'h3);
        set_mode(MODE_RXONLY, 1'b0);
        bus_dom <= 1'b1;
        cyc(8);
        chk(drv_en | rxd, 1'b0, "rx-only wrong");
        bus_dom <= 1'b0;
        chip <= 5'h08;
        set_mode(MODE_NORMAL, 1'b0);
        chk(drv_en, 1'b0, "normal outside chip normal");
        arm <= 1'b0;
        early <= 1'b0;
        chip <= 5'h02;
        set_mode(MODE_WAKE, 1'b1);
        wake_pat();
        chk(rxd | int_n, 1'b0, "wake not signalled");
        chk(wd_cnt == 1, 1'b1, "watchdog not enabled");
        axi_rd(ADDR_WAKE, 32'h1, 32'h1, RESP_OKAY);
        axi_rd(ADDR_CTRL, 32'h1, 32'h3, RESP_OKAY);
        axi_wr(ADDR_WAKE, 32'h1);
        cyc(2);
        chk(int_n, 1'b1, "interrupt not cleared");
        chk(rxd, 1'b0, "rx released early");
        wake_pat();
        axi_rd(ADDR_WAKE, 32'h0, 32'h1, RESP_OKAY);
        set_mode(MODE_OFF, 1'b0);
        chk(rxd, 1'b1, "rx held after mode change");
        set_mode(MODE_WAKE, 1'b0);
        wake_pat();
        axi_rd(ADDR_WAKE, 32'h1, 32'h1, RESP_OKAY);
        axi_wr(ADDR_WAKE, 32'h1);
        set_mode(MODE_OFF, 1'b0);
        set_mode(MODE_WAKE, 1'b0);
        chip <= 5'h04;
        wake_pat();
        chk(rs_cnt == 1, 1'b1, "no restart request");
        chk(int_n & !rxd, 1'b1, "sleep wake signals");
        chip <= 5'h02;
        cyc(4);
        axi_wr(ADDR_WAKE, 32'h1);
        wake_pat();
        axi_rd(ADDR_WAKE, 32'h1, 32'h1, RESP_OKAY);
        chip <= 5'h01;
        axi_wr(ADDR_STATUS, 32'h3);
        set_mode(MODE_NORMAL, 1'b0);
        arm <= 1'b1;
        wait_ready();
        tx_bit <= 1'b0;
        cyc(TX_TO_CYC + 20);
        chk(drv_en, 1'b0, "no transmit time-out");
        axi_rd(ADDR_STATUS, 32'h5, 32'h5, RESP_OKAY);
        axi_rd(ADDR_CTRL, 32'h3, 32'h3, RESP_OKAY);
        tx_bit <= 1'b1;
        cyc(10);
        chk(drv_en, 1'b1, "no return to normal");
        cyc(4);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
